/* File: logic/cqe_pkg.sv */
// constants and types for the command qualifier encoder
package cqe_pkg;
  // database point type codes
  localparam logic [7:0] CQE_DT_SINGLE = 8'h01;
  localparam logic [7:0] CQE_DT_DOUBLE = 8'h03;
  localparam logic [7:0] CQE_DT_STEP = 8'h05;
  localparam logic [7:0] CQE_DT_BITS32 = 8'h07;
  localparam logic [7:0] CQE_DT_NORM = 8'h09;
  localparam logic [7:0] CQE_DT_SCALED = 8'h0b;
  localparam logic [7:0] CQE_DT_FLOAT = 8'h0d;
  localparam logic [7:0] CQE_DT_TOTALS = 8'h0f;
  localparam logic [7:0] CQE_DT_PNORM = 8'h6e;
  localparam logic [7:0] CQE_DT_PSCALED = 8'h6f;
  localparam logic [7:0] CQE_DT_PFLOAT = 8'h70;
  localparam logic [7:0] CQE_DT_BCD = 8'hf0;
  localparam logic [1:0] CQE_WORDS_ONE = 2'h1;
  localparam logic [1:0] CQE_WORDS_TWO = 2'h2;
  localparam logic [1:0] CQE_WORDS_THREE = 2'h3;
  // command type codes
  localparam logic [7:0] CQE_CMD_SINGLE = 8'h2d;
  localparam logic [7:0] CQE_CMD_DOUBLE = 8'h2e;
  localparam logic [7:0] CQE_CMD_STEP = 8'h2f;
  localparam logic [7:0] CQE_CMD_SP_NORM = 8'h30;
  localparam logic [7:0] CQE_CMD_SP_SCALED = 8'h31;
  localparam logic [7:0] CQE_CMD_SP_FLOAT = 8'h32;
  localparam logic [7:0] CQE_CMD_BITS32 = 8'h33;
  localparam logic [7:0] CQE_CMD_INTERRO = 8'h64;
  localparam logic [7:0] CQE_CMD_CNT_INTERRO = 8'h65;
  localparam logic [7:0] CQE_CMD_READ = 8'h66;
  localparam logic [7:0] CQE_CMD_CLOCK = 8'h67;
  localparam logic [7:0] CQE_CMD_TEST = 8'h68;
  localparam logic [7:0] CQE_CMD_TEST_TT = 8'h6b;
  // qualifier field positions
  localparam int CQE_Q_STATE_LSB = 0;
  localparam int CQE_Q_KIND_LSB = 2;
  localparam int CQE_Q_SE_BIT = 7;
  localparam int CQE_Q_DESEL_BIT = 8;
  localparam int CQE_Q_OVR_BIT = 9;
  localparam int CQE_Q_FR_LSB = 6;
  // field codes
  localparam logic [1:0] CQE_DP_OFF = 2'h1;
  localparam logic [1:0] CQE_DP_ON = 2'h2;
  localparam logic [1:0] CQE_STEP_LOWER = 2'h1;
  localparam logic [1:0] CQE_STEP_HIGHER = 2'h2;
  localparam logic [31:0] CQE_DB_MINUS1 = 32'hffffffff;
  localparam logic [31:0] CQE_DB_PLUS1 = 32'h00000001;
  localparam logic [1:0] CQE_SP_DIRECT = 2'h0;
  localparam logic [1:0] CQE_SP_DESELECT = 2'h2;
  localparam logic [7:0] CQE_GI_STATION = 8'h14;
  localparam logic [7:0] CQE_GI_LAST = 8'h24;
  localparam logic [7:0] CQE_GI_PRIVATE = 8'h40;
  localparam logic [5:0] CQE_CI_GENERAL = 6'h05;
  localparam logic [5:0] CQE_CI_PRIVATE = 6'h20;
  localparam logic [1:0] CQE_CS_MEASURE = 2'h2;

  typedef enum logic [2:0]
  {
    CQE_IDLE = 3'b001,
    CQE_BUILD = 3'b010,
    CQE_DONE = 3'b100
  } cqe_state_e;

  typedef enum logic [1:0]
  {
    CQE_EXEC_DIRECT = 2'h0,
    CQE_EXEC_SELECT = 2'h1,
    CQE_EXEC_DESELECT = 2'h2
  } cqe_exec_e;
endpackage

/* File: logic/cqe_dec_if.sv */
// decode signals between the encoder top and its decoder
`timescale 1ns/100ps
`default_nettype none
interface cqe_dec_if;
  logic [7:0] cmd;
  logic [15:0] qual;
  logic [31:0] db_value;
  logic [7:0] user_type;
  logic user_type_en;
  logic [31:0] value;
  logic [7:0] qoc;
  logic [7:0] out_type;
  logic uses_db;
  logic err;
  modport top (output cmd, qual, db_value, user_type, user_type_en,
    input value, qoc, out_type, uses_db, err);
  modport dec (input cmd, qual, db_value, user_type, user_type_en,
    output value, qoc, out_type, uses_db, err);
endinterface
`default_nettype wire

/* File: logic/cqe_decoder.sv */
// combinational qualifier decoder for one command record
`timescale 1ns/100ps
`default_nettype none
module cqe_decoder
(
  cqe_dec_if.dec d
);
  import cqe_pkg::*;
  logic [1:0] st;
  logic [4:0] kind;
  logic se;
  logic desel;
  logic ovr;
  logic [5:0] cgrp;
  logic [1:0] fr;

  always_comb
  begin
    st = d.qual[CQE_Q_STATE_LSB +: 2];
    kind = d.qual[CQE_Q_KIND_LSB +: 5];
    se = d.qual[CQE_Q_SE_BIT];
    desel = d.qual[CQE_Q_DESEL_BIT];
    ovr = d.qual[CQE_Q_OVR_BIT];
    cgrp = d.qual[5:0];
    fr = d.qual[CQE_Q_FR_LSB +: 2];
    d.value = '0;
    d.qoc = '0;
    d.uses_db = 1'b0;
    d.err = 1'b0;
    d.out_type = d.user_type_en ? d.user_type : d.cmd;
    case (d.cmd)
      CQE_CMD_SINGLE, CQE_CMD_DOUBLE, CQE_CMD_STEP:
      begin
        // qualifier of command: pulse kind plus select bit
        d.qoc[6:2] = kind;
        if (se && desel)
          d.err = 1'b1;
        d.qoc[7] = se;
        d.uses_db = ~ovr;
        if (d.cmd == CQE_CMD_SINGLE)
          d.value[0] = ovr ? st[0] : d.db_value[0];
        else if (d.cmd == CQE_CMD_DOUBLE)
        begin
          d.value[1:0] = ovr ? st : d.db_value[1:0];
          if (d.value[1:0] != CQE_DP_OFF && d.value[1:0] != CQE_DP_ON)
            d.err = 1'b1;
        end
        else if (ovr)
        begin
          d.value[1:0] = st;
          if (st != CQE_STEP_LOWER && st != CQE_STEP_HIGHER)
            d.err = 1'b1;
        end
        else if (d.db_value == CQE_DB_MINUS1)
          d.value[1:0] = CQE_STEP_LOWER;
        else if (d.db_value == CQE_DB_PLUS1)
          d.value[1:0] = CQE_STEP_HIGHER;
        else
          d.err = 1'b1;
      end
      CQE_CMD_SP_NORM, CQE_CMD_SP_SCALED, CQE_CMD_SP_FLOAT:
      begin
        d.value = d.db_value;
        d.uses_db = 1'b1;
        d.qoc[7] = (d.qual[1:0] == 2'(CQE_EXEC_SELECT));
        if (d.qual[1:0] > CQE_SP_DESELECT || d.qual[15:2] != '0)
          d.err = 1'b1;
      end
      CQE_CMD_BITS32:
      begin
        d.value = d.db_value;
        d.uses_db = 1'b1;
      end
      CQE_CMD_INTERRO:
      begin
        d.qoc = d.qual[7:0];
        if (d.qual[7:0] < CQE_GI_STATION || (d.qual[7:0] > CQE_GI_LAST
          && d.qual[7:0] < CQE_GI_PRIVATE) || d.qual[15:8] != '0)
          d.err = 1'b1;
      end
      CQE_CMD_CNT_INTERRO:
      begin
        d.qoc = {fr, cgrp};
        if ((cgrp > CQE_CI_GENERAL && cgrp < CQE_CI_PRIVATE)
          || d.qual[15:8] != '0)
          d.err = 1'b1;
      end
      CQE_CMD_CLOCK:
      begin
        d.qoc = {6'h00, d.qual[1:0]};
        if (d.qual[1:0] > CQE_CS_MEASURE || d.qual[15:2] != '0)
          d.err = 1'b1;
      end
      CQE_CMD_READ, CQE_CMD_TEST, CQE_CMD_TEST_TT:
      begin
        d.qoc = '0;
      end
      default:
      begin
        d.qoc = '0;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: logic/cqe_encoder.sv */
// command qualifier encoder top: registers one built command per request
//
// Behaviour
// - monitored point types are coded 1,3,5,7,9,11,13,15 by kind.
// - types 110 and 111 take one word, 112 two and 240 three per point.
// - a user type code replaces the listed code and is passed on as is.
// - single state is bit 0; double uses 1 off, 2 on, others illegal.
// - step without override maps database -1 to 1 and +1 to 2.
// - qualifier bits 2..6 pick none, short, long or persistent output.
// - 0 direct, 128 select before execute, 256 deselect.
// - with 512 the qualifier state is sent, else the database value.
// - setpoints 48..50 send database value with 0/1/2 exec codes.
// - bitstring 51 sends the database value and ignores qualifier.
// - interrogation 100 asks one group: 20 station, 21..36 groups.
// - counter interrogation 101 carries group 0..5 in low bits.
// - freeze/reset field is 0, 64, 128 or 192.
// - clock sync 103 qualifier is 0, 1 or 2.
// - read and test commands use no database value nor qualifier.
`timescale 1ns/100ps
`default_nettype none
module cqe_encoder
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic BUILD_REQ,
  input wire logic [7:0] CMD_TYPE,
  input wire logic [15:0] QUALIFIER,
  input wire logic [31:0] DB_VALUE,
  input wire logic USER_TYPE_EN,
  input wire logic [7:0] USER_TYPE,
  input wire logic [7:0] POINT_TYPE,
  output logic [1:0] POINT_WORDS,
  output logic POINT_MONITORED,
  output logic CMD_VALID,
  output logic CMD_ERROR,
  output logic [7:0] CMD_OUT_TYPE,
  output logic [7:0] CMD_QUAL_OUT,
  output logic [31:0] CMD_VALUE_OUT,
  output logic CMD_USES_DB
);
  import cqe_pkg::*;

  typedef struct packed
  {
    cqe_state_e state;
    logic valid;
    logic error;
    logic [7:0] otype;
    logic [7:0] qoc;
    logic [31:0] value;
    logic uses_db;
    logic [1:0] words;
    logic mon;
  } cqe_regs_s;

  cqe_regs_s r_q;
  cqe_regs_s r_d;
  cqe_dec_if dif ();

  assign dif.cmd = CMD_TYPE;
  assign dif.qual = QUALIFIER;
  assign dif.db_value = DB_VALUE;
  assign dif.user_type = USER_TYPE;
  assign dif.user_type_en = USER_TYPE_EN;

  cqe_decoder u_dec
  (
    .d(dif.dec)
  );

  always_comb
  begin
    r_d = r_q;
    r_d.valid = 1'b0;
    // database geometry follows the point type
    case (POINT_TYPE)
      CQE_DT_PNORM, CQE_DT_PSCALED:
        r_d.words = CQE_WORDS_ONE;
      CQE_DT_PFLOAT:
        r_d.words = CQE_WORDS_TWO;
      CQE_DT_BCD:
        r_d.words = CQE_WORDS_THREE;
      default:
        r_d.words = CQE_WORDS_ONE;
    endcase
    case (POINT_TYPE)
      CQE_DT_SINGLE, CQE_DT_DOUBLE, CQE_DT_STEP, CQE_DT_BITS32,
      CQE_DT_NORM, CQE_DT_SCALED, CQE_DT_FLOAT, CQE_DT_TOTALS:
        r_d.mon = 1'b1;
      default:
        r_d.mon = 1'b0;
    endcase
    case (r_q.state)
      CQE_IDLE:
      begin
        if (BUILD_REQ)
          r_d.state = CQE_BUILD;
      end
      CQE_BUILD:
      begin
        // two cycles of latency from the request keep outputs off the input paths
        r_d.otype = dif.out_type;
        r_d.qoc = dif.qoc;
        r_d.value = dif.value;
        r_d.uses_db = dif.uses_db;
        r_d.error = dif.err;
        r_d.valid = ~dif.err;
        r_d.state = CQE_DONE;
      end
      CQE_DONE:
        r_d.state = CQE_IDLE;
      default:
        r_d.state = CQE_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      r_q <= '0;
      r_q.state <= CQE_IDLE;
    end
    else
      r_q <= r_d;
  end

  assign POINT_WORDS = r_q.words;
  assign POINT_MONITORED = r_q.mon;
  assign CMD_VALID = r_q.valid;
  assign CMD_ERROR = r_q.error;
  assign CMD_OUT_TYPE = r_q.otype;
  assign CMD_QUAL_OUT = r_q.qoc;
  assign CMD_VALUE_OUT = r_q.value;
  assign CMD_USES_DB = r_q.uses_db;
endmodule
`default_nettype wire

/* File: tb/cqe_checker.sv */
// port assertions for the command qualifier encoder
`timescale 1ns/100ps
`default_nettype none
module cqe_checker
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic BUILD_REQ,
  input wire logic [7:0] CMD_TYPE,
  input wire logic USER_TYPE_EN,
  input wire logic [7:0] USER_TYPE,
  input wire logic [7:0] POINT_TYPE,
  input wire logic [1:0] POINT_WORDS,
  input wire logic POINT_MONITORED,
  input wire logic CMD_VALID,
  input wire logic CMD_ERROR,
  input wire logic [7:0] CMD_OUT_TYPE,
  input wire logic [7:0] CMD_QUAL_OUT
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);
  property p_pulse;
    CMD_VALID |=> !CMD_VALID;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("valid held over one cycle");
  property p_cause;
    CMD_VALID |-> $past(BUILD_REQ, 2);
  endproperty
  a_cause: assert property (p_cause)
    else $error("valid without request");
  property p_excl;
    !(CMD_VALID && CMD_ERROR);
  endproperty
  a_excl: assert property (p_excl)
    else $error("valid and error together");
  property p_float;
    POINT_TYPE == 8'h70 |=> POINT_WORDS == 2'h2;
  endproperty
  a_float: assert property (p_float)
    else $error("float words wrong");
  property p_bcd;
    POINT_TYPE == 8'hf0 |=> POINT_WORDS == 2'h3;
  endproperty
  a_bcd: assert property (p_bcd)
    else $error("bcd words wrong");
  property p_mon;
    (POINT_TYPE[0] && POINT_TYPE < 8'h10) |=> POINT_MONITORED;
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitored flag missing");
  property p_type;
    CMD_VALID |-> CMD_OUT_TYPE == ($past(USER_TYPE_EN, 1) ?
      $past(USER_TYPE, 1) : $past(CMD_TYPE, 1));
  endproperty
  a_type: assert property (p_type)
    else $error("sent type code wrong");
  property p_noqual;
    (CMD_VALID && $past(CMD_TYPE, 1) inside {8'h33, 8'h66, 8'h68, 8'h6b})
      |-> CMD_QUAL_OUT == 8'h00;
  endproperty
  a_noqual: assert property (p_noqual)
    else $error("qualifier not ignored");
endmodule
`default_nettype wire

/* File: tb/cqe_outstation.sv */
// controlled station model: takes only clean commands
`timescale 1ns/100ps
`default_nettype none
module cqe_outstation
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic valid,
  input wire logic err,
  output logic [15:0] rx_count
);
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rx_count <= 16'h0;
    else if (valid && !err)
      rx_count <= rx_count + 16'h1;
  end
endmodule
`default_nettype wire

/* File: tb/cqe_encoder_tb.sv */
// self-checking bench for the command qualifier encoder
`timescale 1ns/100ps
`default_nettype none
module cqe_encoder_tb;
  logic REF_CLK = 1'b0, NRST = 1'b0, BUILD_REQ = 1'b0, USER_TYPE_EN = 1'b0;
  logic [7:0] CMD_TYPE = 8'h0, USER_TYPE = 8'h0, POINT_TYPE = 8'h0, c;
  logic [15:0] QUALIFIER = 16'h0, q, rx_count;
  logic [31:0] DB_VALUE = 32'h0, d;
  logic [1:0] POINT_WORDS;
  logic POINT_MONITORED, CMD_VALID, CMD_ERROR, CMD_USES_DB;
  logic [7:0] CMD_OUT_TYPE, CMD_QUAL_OUT;
  logic [31:0] CMD_VALUE_OUT;
  int num_errors = 0, tests_run = 0, nval = 0, seed = 27154;
  logic [55:0] corner [] = '{56'h2f0000ffffffff, 56'h2f008400000001,
    56'h2f000000000000, 56'h2f020200000000, 56'h2e020000000000,
    56'h2e020300000000, 56'h2e020a00000000, 56'h2d020d00000000,
    56'h2d038000000000, 56'h2e030100000000, 56'h30000012345678,
    56'h31000112345678, 56'h32000212345678, 56'h30000312345678,
    56'h33ffffdeadbeef, 56'h64001300000000, 56'h64001400000000,
    56'h64002400000000, 56'h64002500000000, 56'h64004000000000,
    56'h64011400000000, 56'h65000500000000, 56'h65000600000000,
    56'h65002000000000, 56'h6500c100000000, 56'h66ffff00000000,
    56'h67000000000000, 56'h67000200000000, 56'h67000300000000,
    56'h68ffff00000000, 56'h6b123400000000, 56'h2d000800000001,
    56'h2e008c00000002, 56'h2e000000000003, 56'h7f00ff00000000};
  logic [7:0] cmds [14] = '{8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32,
    8'h33, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h6b, 8'h2f};
  always #2.5 REF_CLK = ~REF_CLK;
  cqe_encoder u_cqe_encoder (.REF_CLK(REF_CLK), .NRST(NRST),
    .BUILD_REQ(BUILD_REQ), .CMD_TYPE(CMD_TYPE), .QUALIFIER(QUALIFIER),
    .DB_VALUE(DB_VALUE), .USER_TYPE_EN(USER_TYPE_EN),
    .USER_TYPE(USER_TYPE), .POINT_TYPE(POINT_TYPE),
    .POINT_WORDS(POINT_WORDS), .POINT_MONITORED(POINT_MONITORED),
    .CMD_VALID(CMD_VALID), .CMD_ERROR(CMD_ERROR),
    .CMD_OUT_TYPE(CMD_OUT_TYPE), .CMD_QUAL_OUT(CMD_QUAL_OUT),
    .CMD_VALUE_OUT(CMD_VALUE_OUT), .CMD_USES_DB(CMD_USES_DB));
  cqe_outstation u_cqe_outstation (.clk(REF_CLK), .nrst(NRST),
    .valid(CMD_VALID), .err(CMD_ERROR), .rx_count(rx_count));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("tests %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // packed expectation: error, uses_db, qualifier octet, value
  function automatic logic [41:0] expf(input logic [7:0] c,
    input logic [15:0] q, input logic [31:0] d);
    logic e;
    logic [31:0] v;
    if (c >= 8'h2d && c <= 8'h2f)
    begin
      v = q[9] ? q[1:0] : (d == 32'hffffffff ? 1 : d == 32'h1 ? 2 : 0);
      if (c == 8'h2e && !q[9])
        v = d[1:0];
      if (c == 8'h2d)
        v = q[9] ? q[0] : d[0];
      e = (q[7] && q[8]) || (c != 8'h2d && (v == 0 || v == 3));
      return {e, !q[9], q[7], q[6:2], 2'b00, v};
    end
    case (c)
      8'h30, 8'h31, 8'h32: return {q > 2, 1'b1, q == 1, 7'h0, d};
      8'h33: return {2'b01, 8'h00, d};
      8'h64: return {q < 20 || (q > 36 && q < 64) || q > 255, 1'b0,
        q[7:0], 32'h0};
      8'h65: return {q[5:0] > 5 && q[5:0] < 32, 1'b0, q[7:0], 32'h0};
      8'h67: return {q > 2, 1'b0, q[7:0], 32'h0};
      default: return {2'b00, 8'h00, 32'h0};
    endcase
  endfunction
  task automatic build(input logic [7:0] c, input logic [15:0] q,
    input logic [31:0] d);
    logic [41:0] e;
    e = expf(c, q, d);
    {CMD_TYPE, QUALIFIER, DB_VALUE} = {c, q, d};
    {USER_TYPE_EN, USER_TYPE} = {d[5], d[23:16]};
    BUILD_REQ = 1'b1;
    @(negedge REF_CLK);
    BUILD_REQ = 1'b0;
    // valid stands for one cycle only
    @(negedge REF_CLK);
    chk(CMD_ERROR, e[41]);
    chk(CMD_VALID, !e[41]);
    if (!e[41])
    begin
      nval++;
      chk(CMD_QUAL_OUT, e[39:32]);
      chk(CMD_VALUE_OUT, e[31:0]);
      chk(CMD_USES_DB, e[40]);
      chk(CMD_OUT_TYPE, d[5] ? d[23:16] : c);
    end
    $display("build %h q %h done, tests %0d", c, q, tests_run);
    // a request during the done state would be ignored
    @(negedge REF_CLK);
  endtask
  initial
  begin
    #40000;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(negedge REF_CLK);
    chk({CMD_VALID, CMD_ERROR, POINT_WORDS, CMD_QUAL_OUT}, 32'h0);
    NRST = 1'b1;
    for (int i = 0; i < 256; i++)
    begin
      POINT_TYPE = i[7:0];
      @(negedge REF_CLK);
      chk(POINT_WORDS, i == 112 ? 2 : i == 240 ? 3 : 1);
      chk(POINT_MONITORED, i[0] && i < 16);
    end
    foreach (corner[i])
      build(corner[i][55:48], corner[i][47:32], corner[i][31:0]);
    repeat (150)
    begin
      c = cmds[$unsigned($random(seed)) % 14];
      q = $random(seed);
      d = $random(seed);
      // qualifiers are masked per command except read and test, which stay fully random; illegal codes still occur
      if (c < 8'h30)
      begin
        q = q & 16'h038f;
        q[9] = q[9] || c != 8'h2f;
        d[31:1] = {31{d[31]}};
        d[0] = 1'b1;
      end
      else if (c < 8'h33 || c == 8'h67)
        q = q & 16'h3;
      else if (c < 8'h66)
        q = q & 16'hff;
      build(c, q, d);
    end
    chk(rx_count, nval);
    end_of_test();
  end
endmodule
bind cqe_encoder cqe_checker u_cqe_checker (.REF_CLK(REF_CLK), .NRST(NRST),
  .BUILD_REQ(BUILD_REQ), .CMD_TYPE(CMD_TYPE), .USER_TYPE_EN(USER_TYPE_EN),
  .USER_TYPE(USER_TYPE), .POINT_TYPE(POINT_TYPE),
  .POINT_WORDS(POINT_WORDS), .POINT_MONITORED(POINT_MONITORED),
  .CMD_VALID(CMD_VALID), .CMD_ERROR(CMD_ERROR),
  .CMD_OUT_TYPE(CMD_OUT_TYPE), .CMD_QUAL_OUT(CMD_QUAL_OUT));
`default_nettype wire
